/* hdl/pdt_pkg.sv */
// constants and types shared by the prescaled down timer
package pdt_pkg;

  localparam logic [7:0] ADDR_PRESCALER = 8'hD2;
  localparam logic [7:0] ADDR_COUNT     = 8'hD3;
  localparam logic [7:0] ADDR_STATUS    = 8'hD4;

  localparam logic [7:0] RST_PRESCALER  = 8'h7F;
  localparam logic [7:0] RST_COUNT      = 8'hFF;
  localparam logic [7:0] RST_STATUS     = 8'h00;

  localparam logic [6:0] PSC_RELOAD     = 7'h7F;
  localparam logic [7:0] COUNT_ONE      = 8'h01;
  localparam logic [7:0] COUNT_ZERO     = 8'h00;
  localparam logic [7:0] READ_IDLE      = 8'h00;

  localparam int unsigned BIT_ZERO_FLAG = 7;
  localparam int unsigned BIT_IRQ_EN    = 6;
  localparam int unsigned BIT_PIN_DIR   = 5;
  localparam int unsigned BIT_DATA_OUT  = 4;
  localparam int unsigned BIT_PSC_RUN   = 3;
  localparam int unsigned SEL_MSB       = 2;

  localparam int unsigned INT_DIVIDE    = 12;
  localparam logic [3:0]  DIV_LAST      = 4'(INT_DIVIDE - 1);
  localparam logic [3:0]  DIV_FIRST     = 4'h0;

  typedef enum logic [1:0] {
    PDT_EVENT    = 2'b00,
    PDT_GATED    = 2'b01,
    PDT_OUT_LOW  = 2'b10,
    PDT_OUT_HIGH = 2'b11
  } pdt_mode_type;

endpackage : pdt_pkg

/* hdl/pdt_psc_if.sv */
// carrier between the register top and the prescaler core
`timescale 1ns/1ps
`default_nettype none
interface pdt_psc_if;
  logic                  run;
  logic [2:0]            sel;
  pdt_pkg::pdt_mode_type mode;
  logic                  freeze;
  logic                  pin_high;
  logic                  pin_rise;
  logic                  wr_en;
  logic [6:0]            wr_data;
  logic [6:0]            state;
  logic                  count_tick;

  modport ctrl (output run, sel, mode, freeze, pin_high, pin_rise, wr_en, wr_data,
                input state, count_tick);
  modport core (input run, sel, mode, freeze, pin_high, pin_rise, wr_en, wr_data,
                output state, count_tick);
endinterface : pdt_psc_if
`default_nettype wire

/* hdl/pdt_pin_sync.sv */
// timer pin synchroniser with level and rising edge
`timescale 1ns/1ps
`default_nettype none
module pdt_pin_sync (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      // reset to the pulled-up idle level so release gives no false edge
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      last_r <= 1'b1;
    end
    else
    begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign rise_o  = sync_r & ~last_r;
endmodule : pdt_pin_sync
`default_nettype wire

/* hdl/pdt_prescaler.sv */
// divide-by-twelve source, 7-bit prescaler and tap select
`timescale 1ns/1ps
`default_nettype none
module pdt_prescaler (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  pdt_psc_if.core   psc
);
  logic [3:0] div_r;
  logic [6:0] psc_r;
  logic       int_tick;
  logic       src_tick;
  logic [6:0] tap_mask;

  // internal frequency over twelve; held while frozen
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      div_r <= pdt_pkg::DIV_FIRST;
    else if (!psc.freeze)
      div_r <= (div_r == pdt_pkg::DIV_LAST) ? pdt_pkg::DIV_FIRST : div_r + 4'h1;
  end

  assign int_tick = (div_r == pdt_pkg::DIV_LAST);

  // prescaler source per mode
  always_comb
  begin
    unique case (psc.mode)
      pdt_pkg::PDT_EVENT: src_tick = psc.pin_rise;
      pdt_pkg::PDT_GATED: src_tick = int_tick & psc.pin_high;
      pdt_pkg::PDT_OUT_LOW,
      pdt_pkg::PDT_OUT_HIGH: src_tick = int_tick;
    endcase
  end

  assign tap_mask = 7'((8'h01 << psc.sel) - 8'h01);

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      psc_r <= pdt_pkg::PSC_RELOAD;
    else if (!psc.run)
      psc_r <= pdt_pkg::PSC_RELOAD;
    else if (psc.wr_en)
      psc_r <= psc.wr_data;
    else if (src_tick && !psc.freeze)
      psc_r <= (psc_r == 7'h00) ? pdt_pkg::PSC_RELOAD : psc_r - 7'h01;
  end

  assign psc.count_tick = psc.run & src_tick & ~psc.freeze & ~psc.wr_en & ((psc_r & tap_mask) == 7'h00);
  assign psc.state      = psc_r;
endmodule : pdt_prescaler
`default_nettype wire

/* hdl/pdt_timer.sv */
// prescaled 8-bit down timer with register port and timer pin
//
// How it works
// - counter is always eight-bit down
// - underflow to zero sets zero flag
// - request when enable and flag set
// - writing zero or bit7 sets flag
// - counter writable anytime, counts from value
// - write beats coinciding decrement, no flag
// - direction and data bits select mode
// - gated: twelfth clock while pin high
// - event: pin rising edges clock prescaler
// - output: twelfth clock, pin from latch
// - flag rising edge latches data-out bit
// - direction bit makes pin push-pull output
// - wait runs; enabled zero wakes device
// - stop freezes all except event counting
// - run low forces prescaler, stops counter
// - select field divides by power two
// - prescaler register, bit7 reads zero
// - counter register full eight bits
// - status register layout, resets zero
// - prescaler reloads all ones at zero
// - counter reloads all ones after zero
// - counter ticks once per tap period
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pdt_timer (
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       stop_i,
  input  wire logic       tmr_pin_i,
  output logic            tmr_pin_o,
  output logic            tmr_pin_oe_o,
  output logic            irq_o
);

  logic       rst_meta_r;
  logic       rst_sync_r;
  logic       rst_n;

  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic       flag_r;
  logic       flag_nxt;
  logic       flag_last_r;
  logic       ien_r;
  logic       dir_r;
  logic       dout_r;
  logic       run_r;
  logic [2:0] sel_r;
  logic       latch_r;
  logic       pin_out_r;
  logic       pin_oe_r;
  logic       irq_r;
  logic [7:0] rdata_r;
  logic [7:0] read_mux;

  logic       wr_psc;
  logic       wr_count;
  logic       wr_status;
  logic       underflow;
  logic       pin_level;
  logic       pin_rise;
  logic       freeze;
  logic [7:0] status_view;

  pdt_pkg::pdt_mode_type mode;

  pdt_psc_if psc_bus ();

  // reset released through two flops; assertion stays asynchronous
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_n = rst_sync_r;

  // register decode
  assign wr_psc    = wr_i & (addr_i == pdt_pkg::ADDR_PRESCALER);
  assign wr_count  = wr_i & (addr_i == pdt_pkg::ADDR_COUNT);
  assign wr_status = wr_i & (addr_i == pdt_pkg::ADDR_STATUS);

  assign mode = pdt_pkg::pdt_mode_type'({dir_r, dout_r});

  assign freeze = stop_i & (mode != pdt_pkg::PDT_EVENT);

  pdt_pin_sync u_pin_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n),
    .pin_i   (tmr_pin_i),
    .level_o (pin_level),
    .rise_o  (pin_rise)
  );

  assign psc_bus.run      = run_r;
  assign psc_bus.sel      = sel_r;
  assign psc_bus.mode     = mode;
  assign psc_bus.freeze   = freeze;
  assign psc_bus.pin_high = pin_level;
  assign psc_bus.pin_rise = pin_rise;
  // prescaler write only takes effect while running
  assign psc_bus.wr_en    = wr_psc & run_r;
  assign psc_bus.wr_data  = wdata_i[6:0];

  pdt_prescaler u_prescaler (
    .clock_i (clock_i),
    .rst_n_i (rst_n),
    .psc     (psc_bus.core)
  );

  assign underflow = psc_bus.count_tick & ~wr_count & (count_r == pdt_pkg::COUNT_ONE);

  // counter next value
  always_comb
  begin
    count_nxt = count_r;
    if (wr_count)
      count_nxt = wdata_i;
    else if (psc_bus.count_tick)
      count_nxt = count_r - 8'h01;
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      count_r <= pdt_pkg::RST_COUNT;
    else
      count_r <= count_nxt;
  end

  // flag next value; a hardware set beats a software clear
  always_comb
  begin
    flag_nxt = flag_r;
    if (wr_status)
      flag_nxt = wdata_i[pdt_pkg::BIT_ZERO_FLAG];
    if (wr_count && wdata_i == pdt_pkg::COUNT_ZERO)
      flag_nxt = 1'b1;
    if (underflow)
      flag_nxt = 1'b1;
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      flag_r <= pdt_pkg::RST_STATUS[pdt_pkg::BIT_ZERO_FLAG];
    else
      flag_r <= flag_nxt;
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ien_r  <= pdt_pkg::RST_STATUS[pdt_pkg::BIT_IRQ_EN];
      dir_r  <= pdt_pkg::RST_STATUS[pdt_pkg::BIT_PIN_DIR];
      dout_r <= pdt_pkg::RST_STATUS[pdt_pkg::BIT_DATA_OUT];
      run_r  <= pdt_pkg::RST_STATUS[pdt_pkg::BIT_PSC_RUN];
      sel_r  <= pdt_pkg::RST_STATUS[pdt_pkg::SEL_MSB:0];
    end
    else if (wr_status)
    begin
      ien_r  <= wdata_i[pdt_pkg::BIT_IRQ_EN];
      dir_r  <= wdata_i[pdt_pkg::BIT_PIN_DIR];
      dout_r <= wdata_i[pdt_pkg::BIT_DATA_OUT];
      run_r  <= wdata_i[pdt_pkg::BIT_PSC_RUN];
      sel_r  <= wdata_i[pdt_pkg::SEL_MSB:0];
    end
  end

  // latch data bit on flag rise
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_last_r <= 1'b0;
      latch_r     <= 1'b0;
    end
    else
    begin
      flag_last_r <= flag_r;
      if (flag_r && !flag_last_r)
        latch_r <= dout_r;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_oe_r  <= 1'b0;
      pin_out_r <= 1'b0;
    end
    else
    begin
      pin_oe_r  <= dir_r;
      pin_out_r <= dir_r & latch_r;
    end
  end

  // same level wakes wait or stop
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_r <= 1'b0;
    else
      irq_r <= ien_r & flag_r;
  end

  assign status_view = {flag_r, ien_r, dir_r, dout_r, run_r, sel_r};

  // read mux; unmapped addresses read zero
  always_comb
  begin
    read_mux = pdt_pkg::READ_IDLE;
    unique case (addr_i)
      pdt_pkg::ADDR_PRESCALER: read_mux = {1'b0, psc_bus.state};
      pdt_pkg::ADDR_COUNT:     read_mux = count_r;
      pdt_pkg::ADDR_STATUS:    read_mux = status_view;
      default:                 read_mux = pdt_pkg::READ_IDLE;
    endcase
  end

  // read data stands for one cycle only
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= pdt_pkg::READ_IDLE;
    else if (rd_i)
      rdata_r <= read_mux;
    else
      rdata_r <= pdt_pkg::READ_IDLE;
  end

  assign rdata_o      = rdata_r;
  assign tmr_pin_o    = pin_out_r;
  assign tmr_pin_oe_o = pin_oe_r;
  assign irq_o        = irq_r;

endmodule : pdt_timer
`default_nettype wire

/* tb/pdt_timer_props.sv */
// port assertions for the prescaled down timer
`timescale 1ns/1ps
`default_nettype none
module pdt_timer_props (
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] rdata_o,
  input  wire logic       stop_i,
  input  wire logic       tmr_pin_i,
  input  wire logic       tmr_pin_o,
  input  wire logic       tmr_pin_oe_o,
  input  wire logic       irq_o
);
  logic en_r;
  logic dir_r;
  logic run_r;
  logic st_w;
  assign st_w = wr_i && addr_i == 8'hD4;
  // shadow of the enable, direction and run status bits, updated on the same edge as the block's own copy
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
      {en_r, dir_r, run_r} <= 3'b000;
    else if (st_w)
      {en_r, dir_r, run_r} <= {wdata_i[6:5], wdata_i[3]};
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its slot");
  a_psc_top: assert property ($past(rd_i) && $past(addr_i) == 8'hD2 |-> !rdata_o[7])
    else $error("prescaler top bit not zero");
  a_psc_held: assert property (rd_i && addr_i == 8'hD2 && !run_r && !$past(run_r) |-> ##1 rdata_o == 8'h7F)
    else $error("prescaler not held while stopped");
  a_irq_set: assert property (st_w && wdata_i[7:6] == 2'b11 |-> ##2 irq_o)
    else $error("flag write gave no request");
  a_zero_wr: assert property (wr_i && addr_i == 8'hD3 && wdata_i == 8'h00 && en_r |-> ##2 irq_o)
    else $error("zero count write gave no request");
  a_no_enable: assert property (!en_r |-> ##1 !irq_o)
    else $error("request while disabled");
  a_flag_held: assert property (rd_i && addr_i == 8'hD4 && irq_o && !$past(wr_i) |-> ##1 rdata_o[7:6] == 2'b11)
    else $error("flag lost without software");
  a_oe_follow: assert property (tmr_pin_oe_o == $past(dir_r))
    else $error("pin enable not following direction");
  c_irq: cover property ($rose(irq_o));
  c_oe: cover property ($rose(tmr_pin_oe_o));
  c_pin: cover property ($rose(tmr_pin_o));
endmodule : pdt_timer_props
`default_nettype wire

/* tb/pdt_pin_src.sv */
// far-side source and load on the timer pin
`timescale 1ns/1ps
`default_nettype none
module pdt_pin_src (
  input  wire logic clock_i,
  input  wire logic pin_o_i,
  input  wire logic pin_oe_i,
  output logic      level_o
);
  logic ext_r = 1'b1;
  // device drives push-pull
  // released pin follows the far-side source, which idles at the pull-up level
  assign level_o = pin_oe_i ? pin_o_i : ext_r;
  task automatic hold(input logic v);
    @(posedge clock_i);
    ext_r <= v;
  endtask : hold
  // pulses wide enough for the two-flop synchroniser
  task automatic pulses(input int n);
    repeat (n)
    begin
      hold(1'b0);
      repeat (3) @(posedge clock_i);
      hold(1'b1);
      repeat (3) @(posedge clock_i);
    end
  endtask : pulses
endmodule : pdt_pin_src
`default_nettype wire

/* tb/tb_pdt_timer.sv */
// self-checking bench for the prescaled down timer
`timescale 1ns/1ps
`default_nettype none
module tb_pdt_timer;
  logic       clk   = 1'b0;
  logic       nrst  = 1'b0;
  logic [7:0] addr  = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic       rd_d  = 1'b0;
  logic       stop  = 1'b0;
  logic [7:0] rdata;
  logic       pin_lvl;
  logic       pin_o;
  logic       pin_oe;
  logic       irq;
  logic [7:0] exp_q[$];
  int         n_fail = 0;
  int         total_checks = 0;
  int         k;
  always #2.5 clk = ~clk;
  pdt_timer uut (.clock_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
                 .rdata_o(rdata), .stop_i(stop), .tmr_pin_i(pin_lvl), .tmr_pin_o(pin_o),
                 .tmr_pin_oe_o(pin_oe), .irq_o(irq));
  pdt_pin_src src (.clock_i(clk), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .level_o(pin_lvl));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd   <= 1'b0;
  endtask : rd_reg
  // read data stand only in the cycle after the strobe
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk)
    if (rd_d)
      check(rdata, exp_q.pop_front());
  initial
  begin
    repeat (30000) @(posedge clk);
    n_fail++;
    conclude();
  end
  initial
  begin
    void'($urandom(55));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(8'hD2, 8'h7F);
    rd_reg(8'hD3, 8'hFF);
    rd_reg(8'hD4, 8'h00);
    rd_reg(8'hD5, 8'h00);
    // event counting on taps 0 to 3, odd taps while stopped
    for (int s = 0; s < 4; s++)
    begin
      k = 1 + $urandom % 4;
      stop <= s[0];
      wr_reg(8'hD4, 8'h00);
      rd_reg(8'hD2, 8'h7F);
      wr_reg(8'hD4, 8'h08 | 8'(s));
      wr_reg(8'hD3, 8'h10);
      src.pulses((1 << s) * k);
      repeat (6) @(posedge clk);
      rd_reg(8'hD3, 8'h10 - 8'(k));
      rd_reg(8'hD2, 8'h7F - 8'((1 << s) * k));
    end
    stop <= 1'b0;
    wr_reg(8'hD4, 8'h48);
    wr_reg(8'hD3, 8'h01);
    src.pulses(1);
    repeat (6) @(negedge clk);
    check({7'h00, irq}, 8'h01);
    rd_reg(8'hD4, 8'hC8);
    src.pulses(1);
    repeat (6) @(posedge clk);
    rd_reg(8'hD3, 8'hFF);
    rd_reg(8'hD4, 8'hC8);
    for (int i = 0; i < 2; i++)
    begin
      wr_reg(8'hD4, 8'h48);
      repeat (3) @(negedge clk);
      check({7'h00, irq}, 8'h00);
      wr_reg(i ? 8'hD4 : 8'hD3, i ? 8'hC8 : 8'h00);
      rd_reg(8'hD4, 8'hC8);
    end
    // output pin keeps its latch until the next flag rise
    wr_reg(8'hD4, 8'h30);
    repeat (3) @(negedge clk);
    check({6'h00, pin_oe, pin_lvl}, 8'h02);
    wr_reg(8'hD4, 8'hB0);
    repeat (3) @(negedge clk);
    check({6'h00, pin_oe, pin_lvl}, 8'h03);
    wr_reg(8'hD4, 8'h20);
    repeat (3) @(negedge clk);
    check({6'h00, pin_oe, pin_lvl}, 8'h03);
    // gated with pin low, then output mode while stopped
    src.hold(1'b0);
    for (int i = 0; i < 2; i++)
    begin
      stop <= i[0];
      wr_reg(8'hD4, i ? 8'h28 : 8'h18);
      // let the synchronised pin settle before loading the count
      repeat (4) @(posedge clk);
      wr_reg(8'hD3, 8'h40);
      repeat (60) @(posedge clk);
      rd_reg(8'hD3, 8'h40);
    end
    stop <= 1'b0;
    src.hold(1'b1);
    // gated with pin high counts down to an underflow
    wr_reg(8'hD4, 8'h18);
    repeat (4) @(posedge clk);
    wr_reg(8'hD3, 8'h02);
    repeat (40) @(posedge clk);
    rd_reg(8'hD4, 8'h98);
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule : tb_pdt_timer
bind pdt_timer pdt_timer_props chk (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .stop_i(stop_i), .tmr_pin_i(tmr_pin_i),
  .tmr_pin_o(tmr_pin_o), .tmr_pin_oe_o(tmr_pin_oe_o), .irq_o(irq_o));
`default_nettype wire
